// ==== rdc_pkg.sv ====
// Notes on behaviour
// - Reload cells change only on processor writes and on reset.
// - Write at 0x20 loads low nibble reload.
// - Mask register at 0x22 protects cells.
// - Counter bits map to data bits 7..4.
// - Reload bits map to data bits 3..0.
// - Reload and counter are 4-bit registers.
// - Counter decrements by one per count edge.
// - Terminal count drives port B pin.
// - Bank choice selects which cell register.
// - Exhausted count loads the reload nibble.
// - Logic produces a terminal count output.
package rdc_pkg;

   // Offsets of the two banks inside the I/O register window.
   localparam logic [7:0] RDC_BANK_ONE_OFFSET = 8'h20;
   localparam logic [7:0] RDC_BANK_ONE_MASK_OFFSET = 8'h22;
   localparam logic [7:0] RDC_BANK_TWO_OFFSET = 8'h21;
   localparam logic [7:0] RDC_BANK_TWO_MASK_OFFSET = 8'h23;

   // Field positions within the cell register.
   localparam int RDC_COUNT_LSB = 4;
   localparam int RDC_RELOAD_LSB = 0;
   localparam int RDC_NIBBLE = 4;

   // Reset values and the decrement step.
   localparam logic [3:0] RDC_NIBBLE_RESET = 4'h0;
   localparam logic [7:0] RDC_MASK_RESET = 8'h00;
   localparam logic [3:0] RDC_NIBBLE_ONE = 4'h1;

   // Which output cell bank holds the counter.
   typedef enum logic {
      RDC_BANK_ONE = 1'b0,
      RDC_BANK_TWO = 1'b1
   } rdc_bank_type;

   // One processor bus access toward the cell registers.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rdc_bus_type;

endpackage : rdc_pkg

// ==== rdc_cell.sv ====
`timescale 1ns/1ps
// One 4-bit registered nibble of output cells that only the processor loads.
module rdc_cell
   import rdc_pkg::*;
#(
   parameter int WIDTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [WIDTH-1:0] keep,
   output logic [WIDTH-1:0] value_q
);

   logic [WIDTH-1:0] value_d;

   ////////////////////////////////////////////////////////////////////////
   // Masked bits hold their value; only a load or a reset can change the cells.
   always_comb begin
      value_d = value_q;
      if (load) begin
         value_d = (value_q & keep) | (wdata & ~keep);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         value_q <= '0;
      end else begin
         value_q <= value_d;
      end
   end

endmodule : rdc_cell

// ==== rdc_counter.sv ====
`timescale 1ns/1ps
// Reloading 4-bit down-counter behind the processor's output cell register.
module rdc_counter
   import rdc_pkg::*;
#(
   parameter rdc_bank_type BANK = RDC_BANK_ONE,
   parameter int WIDTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic count_clk,
   input rdc_bus_type bus,
   output logic [7:0] rdata_q,
   output logic port_b_bit_four
);

   localparam logic [7:0] CELL_OFF =
      (BANK == RDC_BANK_ONE) ? RDC_BANK_ONE_OFFSET : RDC_BANK_TWO_OFFSET;
   localparam logic [7:0] MASK_OFF =
      (BANK == RDC_BANK_ONE) ? RDC_BANK_ONE_MASK_OFFSET : RDC_BANK_TWO_MASK_OFFSET;

   logic [1:0] cclk_sync_q;
   logic cclk_prev_q;
   logic [7:0] mask_q;
   logic [7:0] mask_d;
   logic [WIDTH-1:0] counter_vector_q;
   logic [WIDTH-1:0] counter_vector_d;
   logic [WIDTH-1:0] reload_q;
   logic [7:0] rdata_d;
   logic tc_d;
   logic count_edge;
   logic cell_wr;

   ////////////////////////////////////////////////////////////////////////
   // The count clock is a pin, so it is synchronised before edge detection.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cclk_sync_q <= 2'b00;
         cclk_prev_q <= 1'b0;
      end else begin
         cclk_sync_q <= {cclk_sync_q[0], count_clk};
         cclk_prev_q <= cclk_sync_q[1];
      end
   end

   assign count_edge = cclk_sync_q[1] & ~cclk_prev_q;
   assign cell_wr = bus.wr && (bus.addr == CELL_OFF);

   ////////////////////////////////////////////////////////////////////////
   // Reload nibble lives in its own cell module, loaded from data bits 3..0.
   rdc_cell #(
      .WIDTH(WIDTH)
   ) u_reload (
      .clock(clock),
      .rst(rst),
      .load(cell_wr),
      .wdata(bus.wdata[RDC_RELOAD_LSB +: WIDTH]),
      .keep(mask_q[RDC_RELOAD_LSB +: WIDTH]),
      .value_q(reload_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mask register, counter and read data next-state logic.
   always_comb begin
      mask_d = mask_q;
      if (bus.wr && (bus.addr == MASK_OFF)) begin
         mask_d = bus.wdata;
      end
      counter_vector_d = counter_vector_q;
      if (count_edge) begin
         if (counter_vector_q == '0) begin
            counter_vector_d = reload_q;
         end else begin
            counter_vector_d = counter_vector_q - RDC_NIBBLE_ONE;
         end
      end
      // A processor write to the unmasked counter bits wins over counting.
      if (cell_wr) begin
         counter_vector_d = (counter_vector_d & mask_q[RDC_COUNT_LSB +: WIDTH]) |
            (bus.wdata[RDC_COUNT_LSB +: WIDTH] & ~mask_q[RDC_COUNT_LSB +: WIDTH]);
      end
      tc_d = (counter_vector_d == '0);
      rdata_d = rdata_q;
      if (bus.rd) begin
         rdata_d = 8'h00;
         if (bus.addr == CELL_OFF) begin
            rdata_d = {counter_vector_q, reload_q};
         end else if (bus.addr == MASK_OFF) begin
            rdata_d = mask_q;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_q <= RDC_MASK_RESET;
         counter_vector_q <= RDC_NIBBLE_RESET;
         port_b_bit_four <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         mask_q <= mask_d;
         counter_vector_q <= counter_vector_d;
         port_b_bit_four <= tc_d;
         rdata_q <= rdata_d;
      end
   end

endmodule : rdc_counter

// ==== rdc_counter_props.sv ====
`timescale 1ns/1ps
module rdc_counter_props
   import rdc_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic count_clk,
   input wire rdc_bus_type bus,
   input wire logic [7:0] rdata_q,
   input wire logic port_b_bit_four
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // These properties see only the pins, not the mask register.
   // The write checks therefore assume that the counter nibble is unmasked.
   // Four low samples leave no count edge waiting in the synchroniser.
   sequence quiet_s;
      !count_clk [*4];
   endsequence
   bad_read_a:
      assert property (bus.rd && bus.addr == 8'h21 |=> rdata_q == 8'h00) else $error("bad read");
   read_hold_a:
      assert property (!bus.rd |=> $stable(rdata_q)) else $error("read data moved");
   tc_read_a:
      assert property (bus.rd && bus.addr == 8'h20 |=>
         (rdata_q[7:4] == 4'h0) == $past(port_b_bit_four)) else $error("tc vs count");
   tc_write_a:
      assert property (quiet_s ##0 bus.wr && bus.addr == 8'h20 && bus.wdata[7:4] == 4'h0
         |=> port_b_bit_four) else $error("tc not set");
   tc_steady_a:
      assert property (quiet_s ##0 !bus.wr && port_b_bit_four |=> port_b_bit_four)
         else $error("tc dropped");
   tc_clear_a:
      assert property (bus.wr && bus.addr == 8'h20 && bus.wdata[7:4] != 4'h0
         |=> !port_b_bit_four) else $error("tc not cleared");
endmodule : rdc_counter_props
bind rdc_counter rdc_counter_props chk (.clock(clock), .rst(rst), .count_clk(count_clk),
   .bus(bus), .rdata_q(rdata_q), .port_b_bit_four(port_b_bit_four));

// ==== rdc_cpu.sv ====
`timescale 1ns/1ps
// Processor side: one strobe per access, then the lines float to junk.
module rdc_cpu
   import rdc_pkg::*;
(
   input wire logic clock,
   input wire logic [7:0] rdata_q,
   output rdc_bus_type bus
);
   initial bus = '{1'h0, 1'h0, 8'hFF, 8'hFF};
   // Read data is taken once the strobe edge has passed.
   task automatic acc(input logic w, logic [7:0] a, d, output logic [7:0] q);
      @(negedge clock);
      bus = '{w, !w, a, d};
      @(negedge clock);
      bus = '{1'h0, 1'h0, ~a, ~d};
      q = rdata_q;
   endtask : acc
endmodule : rdc_cpu

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(s, x, y) begin comparisons++; if ((y) !== (x)) begin num_errors++; \
   $display("ERROR %s exp %h got %h", s, x, y); end end
module tb;
   import rdc_pkg::*;
   logic clock = 0, rst = 1, count_clk = 0, port_b_bit_four;
   logic [7:0] rdata_q, q;
   logic [3:0] c, r, e;
   rdc_bus_type bus;
   int num_errors = 0, comparisons = 0, seed = 62813, n;
   rdc_counter dut (.clock(clock), .rst(rst), .count_clk(count_clk), .bus(bus),
      .rdata_q(rdata_q), .port_b_bit_four(port_b_bit_four));
   rdc_cpu cpu (.clock(clock), .rdata_q(rdata_q), .bus(bus));
   initial forever #5 clock = ~clock;
   // Expected count: reload when exhausted, else step down by one.
   function automatic logic [3:0] step(logic [3:0] v, ld, int k);
      repeat (k) v = (v == 4'h0) ? ld : v - 4'h1;
      return v;
   endfunction : step
   // One slow count pulse, long enough for the synchroniser.
   task automatic tick;
      @(negedge clock) count_clk = 1'h1;
      repeat (4) @(negedge clock);
      count_clk = 1'h0;
      repeat (4) @(negedge clock);
   endtask : tick
   task automatic wrap_up;
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   initial begin
      #100000 num_errors++;
      wrap_up;
   end
   // Corner case first, then random loads and pulse counts.
   initial begin
      repeat (3) @(negedge clock);
      rst = 1'h0;
      cpu.acc(1'h0, 8'h20, 8'h00, q);
      `CHK("reset cell", 8'h00, q)
      cpu.acc(1'h0, 8'h21, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      for (int i = 0; i < 8; i++) begin
         c = i ? $random(seed) : 4'h1;
         r = i ? $random(seed) : 4'h0;
         n = i ? {$random(seed)} % 20 : 2;
         cpu.acc(1'h1, 8'h20, {c, r}, q);
         cpu.acc(1'h0, 8'h20, 8'h00, q);
         `CHK("load", {c, r}, q)
         repeat (n) tick;
         e = step(c, r, n);
         cpu.acc(1'h0, 8'h20, 8'h00, q);
         `CHK("count", {e, r}, q)
         `CHK("tc", e == 4'h0, port_b_bit_four)
         $display("test %0d done", i);
      end
      // Inverted reload data, so a leaking mask can never match by chance.
      cpu.acc(1'h1, 8'h22, 8'h0F, q);
      cpu.acc(1'h1, 8'h20, {4'hF, ~r}, q);
      cpu.acc(1'h0, 8'h20, 8'h00, q);
      `CHK("masked", {4'hF, r}, q)
      cpu.acc(1'h0, 8'h22, 8'h00, q);
      `CHK("mask", 8'h0F, q)
      cpu.acc(1'h1, 8'h22, 8'hF0, q);
      cpu.acc(1'h1, 8'h20, 8'h5A, q);
      cpu.acc(1'h0, 8'h20, 8'h00, q);
      `CHK("count masked", 8'hFA, q)
      $display("test mask done");
      // A reset in mid-run must clear the count, the reload and the mask.
      @(negedge clock) rst = 1'h1;
      repeat (2) @(negedge clock);
      rst = 1'h0;
      cpu.acc(1'h0, 8'h20, 8'h00, q);
      `CHK("reset cell again", 8'h00, q)
      cpu.acc(1'h0, 8'h22, 8'h00, q);
      `CHK("reset mask", 8'h00, q)
      `CHK("reset tc", 1'h1, port_b_bit_four)
      $display("test reset done");
      wrap_up;
   end
endmodule : tb
